// ---- common/isr_pkg.sv ----
// package: shared constants and carriers of the status reporting block
package isr_pkg;
    localparam int QUES_W = 16;
    localparam int STD_W  = 8;
    localparam int STB_W  = 8;
    // status byte bit positions
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV  = 4;
    localparam int STB_STD  = 5;
    localparam int STB_RQS  = 6;
    // standard event bit positions, then the questionable overload bit
    localparam int STD_OPC  = 0;
    localparam int STD_QRY  = 2;
    localparam int STD_DEV  = 3;
    localparam int STD_EXE  = 4;
    localparam int STD_CMD  = 5;
    localparam int STD_PON  = 7;
    localparam int QUES_OVLD = 0;
    // implemented bits, the others read zero; then the reset values
    localparam logic [QUES_W-1:0] QUES_USED = 16'h03B1;
    localparam logic [STD_W-1:0]  STD_USED  = 8'hBD;
    localparam logic [STB_W-1:0]  STB_RST   = 8'h00;
    localparam logic [QUES_W-1:0] QUES_RST  = 16'h0000;
    localparam logic [STD_W-1:0]  STD_RST   = 8'h00;

    typedef enum logic [3:0] {
        OP_CLS, OP_SRE_WR, OP_SRE_RD, OP_ESE_WR, OP_ESE_RD, OP_ESR_RD,
        OP_STB_RD, OP_QCOND_RD, OP_QEVEN_RD, OP_QENAB_WR, OP_QENAB_RD,
        OP_PRESET, OP_PSC_WR, OP_PSC_RD, OP_OPC, OP_NOP
    } isr_op_t;

    typedef struct packed {
        logic            valid;
        isr_op_t         op;
        logic [15:0]     data;
    } isr_cmd_t;

    typedef struct packed {
        logic            valid;
        logic [15:0]     data;
    } isr_rsp_t;

    typedef struct packed {
        logic            query_err;
        logic            dev_err;
        logic            exe_err;
        logic            cmd_err;
    } isr_evt_t;
endpackage

// ---- tb/isr_host.sv ----
// host controller model: issues commands and serial polls
`timescale 1ns/10ps
module isr_host (
    input  wire logic                      core_clk,
    input  wire logic                      cmd_ready,
    input  wire isr_pkg::isr_rsp_t         rsp,
    input  wire logic                      spoll_valid,
    input  wire logic [isr_pkg::STB_W-1:0] spoll_byte,
    output isr_pkg::isr_cmd_t              cmd,
    output logic                           spoll_req
);
    import isr_pkg::*;
    initial begin
        cmd       = '{valid: 1'b0, op: OP_NOP, data: 16'h0000};
        spoll_req = 1'b0;
    end
    // request held to the taking edge; released data is inverted, never left stale
    task automatic issue(input isr_op_t op, input logic [15:0] d, input bit rd,
                         output logic [15:0] ans);
        ans = 'x;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        cmd = '{valid: 1'b1, op: op, data: d};
        @(negedge core_clk);
        cmd = '{valid: 1'b0, op: OP_NOP, data: ~d};
        for (int i = 0; rd && i < 64; i++) begin
            if (rsp.valid === 1'b1) begin
                ans = rsp.data;
                break;
            end
            @(negedge core_clk);
        end
    endtask
    task automatic poll(output logic [7:0] b);
        b = 'x;
        @(negedge core_clk);
        spoll_req = 1'b1;
        @(negedge core_clk);
        spoll_req = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (spoll_valid === 1'b1) begin
                b = spoll_byte;
                break;
            end
            @(negedge core_clk);
        end
    endtask
endmodule

// ---- tb/tb_instrument_status_reporting.sv ----
// testbench: status registers, service request and serial poll
`timescale 1ns/10ps
module tb_instrument_status_reporting;
    import isr_pkg::*;
    logic core_clk, sys_rst, cmd_ready, spoll_req, spoll_valid, srq, ops_idle;
    logic errq_not_empty, out_pending, dev_clear, psc_stored, out_flush, errq_clear;
    logic output_disable, psc_setting, saw_flush, saw_clr;
    logic [7:0]  spoll_byte, sre_stored, ese_stored, pb;
    logic [15:0] ques_cond, v;
    isr_cmd_t cmd;
    isr_rsp_t rsp;
    isr_evt_t std_evt;
    int error_cnt = 0;
    int tests_run = 0;

    isr_status i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp(rsp), .spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte),
        .srq(srq), .ques_cond(ques_cond), .std_evt(std_evt), .ops_idle(ops_idle),
        .errq_not_empty(errq_not_empty), .out_pending(out_pending), .dev_clear(dev_clear),
        .psc_stored(psc_stored), .sre_stored(sre_stored), .ese_stored(ese_stored),
        .out_flush(out_flush), .errq_clear(errq_clear), .output_disable(output_disable),
        .psc_setting(psc_setting));
    isr_host i_host (.core_clk(core_clk), .cmd_ready(cmd_ready), .rsp(rsp),
        .spoll_valid(spoll_valid), .spoll_byte(spoll_byte), .cmd(cmd), .spoll_req(spoll_req));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // pulses are caught sticky so their exact cycle does not matter
    always @(posedge core_clk) begin
        if (out_flush === 1'b1) saw_flush <= 1'b1;
        if (errq_clear === 1'b1) saw_clr <= 1'b1;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input isr_op_t op, input logic [15:0] exp);
        i_host.issue(op, 16'h0000, 1'b1, v);
        chk(op.name(), v, exp);
    endtask
    task automatic wr(input isr_op_t op, input logic [15:0] d);
        i_host.issue(op, d, 1'b0, v);
    endtask
    task automatic pl(input logic [7:0] exp);
        i_host.poll(pb);
        chk("poll byte", {8'h00, pb}, {8'h00, exp});
    endtask
    task automatic stb(input logic [15:0] exp);
        ops_idle = 1'b0;
        fork
            i_host.issue(OP_STB_RD, 16'h0000, 1'b1, v);
        join_none
        repeat (4) @(negedge core_clk);
        chk("ready while waiting", 16'(cmd_ready), 16'h0000);
        ops_idle = 1'b1;
        wait fork;
        chk("status query", v, exp);
    endtask
    task automatic boot();
        sys_rst = 1'b1;
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial begin
        {ops_idle, errq_not_empty, out_pending, dev_clear} = 4'b1000;
        {psc_stored, sre_stored, ese_stored} = {1'b0, 8'h20, 8'h10};
        {saw_flush, saw_clr, ques_cond, std_evt} = '0;
        boot();
        rd(OP_SRE_RD, 16'h0020);
        rd(OP_ESE_RD, 16'h0010);
        rd(OP_PSC_RD, 16'h0000);
        rd(OP_ESR_RD, 16'h0080);
        rd(OP_ESR_RD, 16'h0000);
        // questionable group: live, latched and cleared views
        ques_cond = 16'hFFFF;
        repeat (3) @(negedge core_clk);
        chk("output disable", 16'(output_disable), 16'h0001);
        rd(OP_QCOND_RD, 16'h03B1);
        rd(OP_QCOND_RD, 16'h03B1);
        rd(OP_QEVEN_RD, 16'h03B1);
        rd(OP_QEVEN_RD, 16'h0000);
        ques_cond = 16'h0000;
        wr(OP_QENAB_WR, 16'h0001);
        wr(OP_SRE_WR, 16'h0008);
        rd(OP_QENAB_RD, 16'h0001);
        {errq_not_empty, out_pending} = 2'b11;
        repeat (3) @(negedge core_clk);
        chk("srq idle", 16'(srq), 16'h0000);
        {ques_cond, errq_not_empty, out_pending} = {16'h0001, 2'b11};
        repeat (3) @(negedge core_clk);
        chk("srq raised", 16'(srq), 16'h0001);
        stb(16'h005C);
        chk("srq kept", 16'(srq), 16'h0001);
        pl(8'h5C);
        chk("srq released", 16'(srq), 16'h0000);
        pl(8'h1C);
        rd(OP_QEVEN_RD, 16'h0001);
        pl(8'h14);
        // standard events, only command error enabled for service request
        wr(OP_SRE_WR, 16'h0020);
        wr(OP_ESE_WR, 16'h0020);
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            std_evt = isr_evt_t'(4'b1000 >> i);
            @(negedge core_clk);
            std_evt = '0;
            repeat (2) @(negedge core_clk);
            chk("srq per event", 16'(srq), 16'(i == 3));
            rd(OP_ESR_RD, 16'h0004 << i);
        end
        pl(8'h54);
        out_pending = 1'b0;
        pl(8'h04);
        ops_idle = 1'b0;
        wr(OP_OPC, 16'h0000);
        rd(OP_ESR_RD, 16'h0000);
        ops_idle = 1'b1;
        repeat (3) @(negedge core_clk);
        rd(OP_ESR_RD, 16'h0001);
        ques_cond = 16'h0010;
        wr(OP_CLS, 16'h0000);
        repeat (3) @(negedge core_clk);
        chk("error queue clear", 16'(saw_clr), 16'h0001);
        rd(OP_QEVEN_RD, 16'h0000);
        dev_clear = 1'b1;
        @(negedge core_clk);
        dev_clear = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("output flush", 16'(saw_flush), 16'h0001);
        wr(OP_PRESET, 16'h0000);
        rd(OP_QENAB_RD, 16'h0000);
        rd(OP_SRE_RD, 16'h0020);
        wr(OP_PSC_WR, 16'h0001);
        chk("psc setting", 16'(psc_setting), 16'h0001);
        rd(OP_PSC_RD, 16'h0001);
        psc_stored = 1'b1;
        boot();
        rd(OP_SRE_RD, 16'h0000);
        rd(OP_ESE_RD, 16'h0000);
        conclude();
    end
endmodule

// ---- verilog/isr_status.sv ----
// module: status registers, service request and serial poll of the instrument
`timescale 1ns/10ps
// What this block does
// - event read clears whole event register and its summary bit
// - request mask cleared by zero write, power-on setting
// - request mask selects bits driving request line
// - request flag rising asserts service request
// - serial poll returns byte, clears flag, releases
// - serial poll answered at once by hardware
// - status query equals poll except bit 6, which holds the live summary
// - status query waits for completion, never clears request
// - message flag set while output data waits
// - device clear empties output buffer, responsive
// - clear status clears events and error queue
// - operation complete set after all commands finish
// - standard events summarised into status bit five
// - overload, temperature, lock loss questionable bits
// - mod overload, calibration, external timebase bits
// - unused questionable bits read zero
// - enabled questionable events form summary bit
// - questionable events cleared by clear or read
// - questionable mask cleared at power-on, preset, zero
// - query error bit on buffer faults
// - device, execution, syntax error bits; unused zero
// - power-on bit set after power comes on
// - enabled standard events form summary bit
// - error queue, questionable summary; unused bits zero
// - event bits latch and stay until cleared
// - condition registers follow state, never cleared
module isr_status #(
    parameter int QW = isr_pkg::QUES_W
) (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire isr_pkg::isr_cmd_t         cmd,
    output logic                           cmd_ready,
    output isr_pkg::isr_rsp_t              rsp,
    input  wire logic                      spoll_req,
    output logic                           spoll_valid,
    output logic [isr_pkg::STB_W-1:0]      spoll_byte,
    output logic                           srq,
    input  wire logic [QW-1:0]             ques_cond,
    input  wire isr_pkg::isr_evt_t         std_evt,
    input  wire logic                      ops_idle,
    input  wire logic                      errq_not_empty,
    input  wire logic                      out_pending,
    input  wire logic                      dev_clear,
    input  wire logic                      psc_stored,
    input  wire logic [isr_pkg::STB_W-1:0] sre_stored,
    input  wire logic [isr_pkg::STD_W-1:0] ese_stored,
    output logic                           out_flush,
    output logic                           errq_clear,
    output logic                           output_disable,
    output logic                           psc_setting
);
    import isr_pkg::*;

    // the bit map of the questionable group is fixed at 16 bits
    if (QW != QUES_W) begin : g_qw_check
        $error("questionable width must be 16");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [QW-1:0]    qcond_reg, qcond_next, qev_reg, qev_next, qen_reg, qen_next;
    logic [STD_W-1:0] sev_reg, sev_next, ese_reg, ese_next;
    logic [STB_W-1:0] sre_reg, sre_next;
    logic             psc_reg, psc_next;
    logic             boot_reg, boot_next;
    logic             opc_pend_reg, opc_pend_next;
    logic             stb_wait_reg, stb_wait_next;
    logic             mss_prev_reg, mss_prev_next;
    logic             rqs_reg, rqs_next;
    isr_rsp_t         rsp_reg, rsp_next;
    logic             spv_reg, spv_next;
    logic [STB_W-1:0] spb_reg, spb_next;
    logic             flush_reg, flush_next, errqc_reg, errqc_next;
    logic             odis_reg, odis_next;
    logic             ready_reg, ready_next;

    logic [STB_W-1:0] stb_cond;
    logic             mss;
    logic             is_cmd;

    // ----------------------------------------------------------------
    // status byte summary
    // ----------------------------------------------------------------
    always_comb begin
        stb_cond           = STB_RST;
        stb_cond[STB_ERRQ] = errq_not_empty;
        stb_cond[STB_QUES] = |(qev_reg & qen_reg);
        stb_cond[STB_MAV]  = out_pending;
        stb_cond[STB_STD]  = |(sev_reg & ese_reg);
        mss                = |(stb_cond & sre_reg);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [QW-1:0]    qset;
        logic [STD_W-1:0] sset;
        logic             qrd_clr, srd_clr, cls;
        qset = '0;
        sset = '0;
        qrd_clr = 1'b0;
        srd_clr = 1'b0;
        cls = 1'b0;
        is_cmd = cmd.valid && ready_reg;
        qcond_next = ques_cond & QUES_USED;
        qen_next = qen_reg;
        ese_next = ese_reg;
        sre_next = sre_reg;
        psc_next = psc_reg;
        boot_next = 1'b0;
        opc_pend_next = opc_pend_reg;
        stb_wait_next = stb_wait_reg;
        rsp_next = '0;
        flush_next = dev_clear;
        errqc_next = 1'b0;
        odis_next = qcond_reg[QUES_OVLD];
        if (boot_reg) begin
            psc_next = psc_stored;
            sre_next = psc_stored ? STB_RST : sre_stored;
            ese_next = psc_stored ? STD_RST : ese_stored;
            qen_next = QUES_RST;
            sset[STD_PON] = 1'b1;
        end
        if (is_cmd) begin
            rsp_next.valid = 1'b1;
            case (cmd.op)
                OP_CLS: begin
                    cls = 1'b1;
                    errqc_next = 1'b1;
                    opc_pend_next = 1'b0;
                end
                OP_SRE_WR: begin
                    sre_next = cmd.data[STB_W-1:0] & ~(8'h40);
                    rsp_next.valid = 1'b0;
                end
                OP_SRE_RD:   rsp_next.data = {8'h00, sre_reg};
                OP_ESE_WR: begin
                    ese_next = cmd.data[STD_W-1:0];
                    rsp_next.valid = 1'b0;
                end
                OP_ESE_RD:   rsp_next.data = {8'h00, ese_reg};
                OP_ESR_RD: begin
                    rsp_next.data = {8'h00, sev_reg};
                    srd_clr = 1'b1;
                end
                OP_STB_RD: begin
                    // result waits until earlier work is finished
                    rsp_next.valid = 1'b0;
                    stb_wait_next = 1'b1;
                end
                OP_QCOND_RD: rsp_next.data = qcond_reg;
                OP_QEVEN_RD: begin
                    rsp_next.data = qev_reg;
                    qrd_clr = 1'b1;
                end
                OP_QENAB_WR: begin
                    qen_next = cmd.data & QUES_USED;
                    rsp_next.valid = 1'b0;
                end
                OP_QENAB_RD: rsp_next.data = qen_reg;
                OP_PRESET: begin
                    qen_next = QUES_RST;
                    rsp_next.valid = 1'b0;
                end
                OP_PSC_WR: begin
                    psc_next = cmd.data[0];
                    rsp_next.valid = 1'b0;
                end
                OP_PSC_RD:   rsp_next.data = {15'h0000, psc_reg};
                OP_OPC: begin
                    opc_pend_next = 1'b1;
                    rsp_next.valid = 1'b0;
                end
                default:     rsp_next.valid = 1'b0;
            endcase
        end
        if (stb_wait_reg && ops_idle) begin
            // bit 6 follows the live summary, so this read clears nothing
            rsp_next.valid = 1'b1;
            rsp_next.data = {8'h00, stb_cond | {1'b0, mss, 6'h00}};
            stb_wait_next = 1'b0;
        end
        if (dev_clear) begin
            stb_wait_next = 1'b0;
            opc_pend_next = 1'b0;
        end
        if (opc_pend_reg && ops_idle && !cls) begin
            sset[STD_OPC] = 1'b1;
            opc_pend_next = 1'b0;
        end
        sset[STD_QRY] = std_evt.query_err;
        sset[STD_DEV] = std_evt.dev_err;
        sset[STD_EXE] = std_evt.exe_err;
        sset[STD_CMD] = std_evt.cmd_err;
        qset = ques_cond & QUES_USED & ~qcond_reg;
        // a new event beats a clear in the same cycle
        qev_next = (qev_reg & ~{QW{qrd_clr | cls}}) | qset;
        sev_next = ((sev_reg & ~{STD_W{srd_clr | cls}}) | sset) & STD_USED;
        mss_prev_next = mss;
        rqs_next = rqs_reg;
        if (spoll_req) rqs_next = 1'b0;
        if (mss && !mss_prev_reg) rqs_next = 1'b1;
        spv_next = spoll_req;
        spb_next = spoll_req ? (stb_cond | {1'b0, rqs_reg, 6'h00}) : spb_reg;
        ready_next = ~stb_wait_next;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            qcond_reg <= QUES_RST;
            qev_reg <= QUES_RST;
            qen_reg <= QUES_RST;
            sev_reg <= STD_RST;
            ese_reg <= STD_RST;
            sre_reg <= STB_RST;
            psc_reg <= 1'b1;
            boot_reg <= 1'b1;
            opc_pend_reg <= 1'b0;
            stb_wait_reg <= 1'b0;
            mss_prev_reg <= 1'b0;
            rqs_reg <= 1'b0;
            rsp_reg <= '0;
            spv_reg <= 1'b0;
            spb_reg <= STB_RST;
            flush_reg <= 1'b0;
            errqc_reg <= 1'b0;
            odis_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            qcond_reg <= qcond_next;
            qev_reg <= qev_next;
            qen_reg <= qen_next;
            sev_reg <= sev_next;
            ese_reg <= ese_next;
            sre_reg <= sre_next;
            psc_reg <= psc_next;
            boot_reg <= boot_next;
            opc_pend_reg <= opc_pend_next;
            stb_wait_reg <= stb_wait_next;
            mss_prev_reg <= mss_prev_next;
            rqs_reg <= rqs_next;
            rsp_reg <= rsp_next;
            spv_reg <= spv_next;
            spb_reg <= spb_next;
            flush_reg <= flush_next;
            errqc_reg <= errqc_next;
            odis_reg <= odis_next;
            ready_reg <= ready_next;
        end
    end

    assign cmd_ready      = ready_reg;
    assign rsp            = rsp_reg;
    assign spoll_valid    = spv_reg;
    assign spoll_byte     = spb_reg;
    assign srq            = rqs_reg;
    assign out_flush      = flush_reg;
    assign errq_clear     = errqc_reg;
    assign output_disable = odis_reg;
    assign psc_setting    = psc_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    srq_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        mss && !mss_prev_reg |=> srq) else $error("request not raised on summary rise");
    poll_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req && !(mss && !mss_prev_reg) |=> !srq && spoll_valid)
        else $error("poll did not release request");
    poll_byte_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req |=> spoll_byte[STB_RQS] == $past(rqs_reg))
        else $error("poll byte bit 6 wrong");
    qev_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_QEVEN_RD && ques_cond == qcond_reg |=> qev_reg == '0)
        else $error("questionable event not cleared by read");
    ques_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ((qev_reg | qcond_reg | qen_reg) & ~QUES_USED) == '0)
        else $error("unused questionable bit set");
    sev_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        sev_reg[STD_CMD] && !(is_cmd && cmd.op inside {OP_CLS, OP_ESR_RD})
        |=> sev_reg[STD_CMD]) else $error("event bit lost");
    stb_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        stb_wait_reg && !ops_idle && !dev_clear |=> !rsp.valid)
        else $error("status query answered too early");
    pon_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        boot_reg |=> sev_reg[STD_PON] && qen_reg == '0)
        else $error("power-on event missing");
    sre_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_SRE_WR && cmd.data == 16'h0000 && !boot_reg
        |=> sre_reg == '0 && !mss) else $error("request mask not cleared");

    // ----------------------------------------------------------------
    // checks: command port and status query
    // ----------------------------------------------------------------
    ready_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        stb_wait_reg |-> !cmd_ready)
        else $error("command port open while query waits");
    stb_answer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        stb_wait_reg && ops_idle |=> rsp.valid && rsp.data[STB_RQS] == $past(mss))
        else $error("status query answer wrong");
    srq_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        srq && !spoll_req |=> srq)
        else $error("request dropped without a poll");
    qen_preset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_PRESET |=> qen_reg == '0)
        else $error("preset left questionable mask set");
    qen_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_QENAB_WR && cmd.data == 16'h0000 |=> qen_reg == '0)
        else $error("zero write left questionable mask set");
    cls_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_CLS && ques_cond == qcond_reg |=> errq_clear && qev_reg == '0)
        else $error("clear status incomplete");
    flush_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        dev_clear |=> out_flush && !stb_wait_reg)
        else $error("device clear not carried out");
    opc_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        opc_pend_reg && ops_idle && !(is_cmd && cmd.op == OP_CLS) |=> sev_reg[STD_OPC])
        else $error("operation complete not flagged");
    psc_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        is_cmd && cmd.op == OP_PSC_WR |=> psc_setting == $past(cmd.data[0]))
        else $error("power-on clear setting not stored");
    sre_boot_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        boot_reg |=> sre_reg == ($past(psc_stored) ? STB_RST : $past(sre_stored)))
        else $error("request mask wrong after power-on");

    // ----------------------------------------------------------------
    // checks: request line and serial poll
    // ----------------------------------------------------------------
    srq_source_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !srq && !(mss && !mss_prev_reg) |=> !srq)
        else $error("request raised without enabled summary rise");
    spv_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !spoll_req |=> !spoll_valid)
        else $error("poll answer without poll");
    poll_mav_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req |=> spoll_byte[STB_MAV] == $past(out_pending))
        else $error("message flag wrong in poll byte");
    poll_errq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req |=> spoll_byte[STB_ERRQ] == $past(errq_not_empty))
        else $error("error queue flag wrong in poll byte");
    poll_unused_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (spoll_byte & 8'h83) == 8'h00)
        else $error("unused poll bit set");
    poll_ques_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req |=> spoll_byte[STB_QUES] == |($past(qev_reg) & $past(qen_reg)))
        else $error("questionable summary wrong in poll byte");
    poll_std_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        spoll_req |=> spoll_byte[STB_STD] == |($past(sev_reg) & $past(ese_reg)))
        else $error("standard event summary wrong in poll byte");

    // ----------------------------------------------------------------
    // checks: event groups
    // ----------------------------------------------------------------
    qev_latch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (qev_reg & qcond_reg & ~$past(qcond_reg)) == (qcond_reg & ~$past(qcond_reg)))
        else $error("condition rise not latched");
    qcond_live_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> qcond_reg == ($past(ques_cond) & QUES_USED))
        else $error("condition register not following state");
    odis_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> output_disable == $past(qcond_reg[QUES_OVLD]))
        else $error("output not disabled on overload");
    sev_unused_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sev_reg & ~STD_USED) == '0)
        else $error("unused standard event bit set");
endmodule
